/* design/cell_balance_pkg.sv */
// Constants for the cell balancing scheduler: register map, field
// positions, reset values and timing. Shared by design and bench.
package cell_balance_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CELL_SELECT = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_TEMP_LIMITS = 8'h08;
    localparam logic [7:0] OFS_DIE_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CELLS = 5;
    localparam int CFG_LOCK_BIT = 0;
    localparam int CFG_DECIM_LSB = 1;
    localparam int CFG_SETTLE_LSB = 3;
    localparam int CFG_LOOP_LSB = 6;
    localparam int TL_MAX_LSB = 16;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_SW_LSB = 1;
    localparam int ST_PEND_BIT = 6;
    localparam int ST_SETTLE_BIT = 7;
    localparam int ST_MEAS_BIT = 8;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [15:0] MIN_TEMP_RST = 16'hFFFF;
    localparam logic [15:0] MAX_TEMP_RST = 16'h0000;
    localparam logic [15:0] DIE_LIMIT_RST = 16'hFFFF;
    // ------------------------------------------------------------
    // Power modes seen on the power_mode input
    // ------------------------------------------------------------
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_SLEEP = 2'h1;
    localparam logic [1:0] PM_DEEP = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int TIMEOUT_S = 20;
    localparam int TIMEOUT_MS = TIMEOUT_S * MS_PER_S;
    localparam int SETTLE_MAX_MS = 64;
    localparam logic [2:0] SLOT_LAST = 3'h7;
endpackage

/* design/cell_balance_scheduler.sv */
// Balancing scheduler: APB registers, safety timeout, interlocks and
// interleaving of balancing switches with the conversion scan.
// Assumes a scan sequencer pulsing slot_tick at each slot boundary,
// eight slots per scan, and holding voltage slots while settle_wait.
`timescale 1ns/1ps

// Function
// - Nonzero mask starts balancing, 20 s limit
// - Each new command restarts the timeout
// - All-zero mask stops all balancing
// - Any cell combination balances together
// - Mask readable at once after write
// - Write lock bit makes mask writes ignored
// - Thermistor and die limits stop balancing
// - Switches off in measure and shared slots
// - Decimation code picks one in 2..16 scans
// - Skipped scans keep their idle slot timing
// - Off one slot before measuring scan
// - Voltage protection only on measured scans
// - Start waits for the running scan end
// - Loop rate when idle, decimation when active
// - Voltage alert ends balancing immediately
// - Active balancing keeps device awake
// - Deep low power ignores and terminates
// - Running flag set at start, cleared off
// - Settle delay after every switch-off
module cell_balance_scheduler #(
    parameter int MS_CYCLES = cell_balance_pkg::MS_CYCLES,
    parameter int TIMEOUT_MS = cell_balance_pkg::TIMEOUT_MS
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Scan sequencer
    input wire logic slot_tick,
    input wire logic shared_slot,
    output logic measure_scan,
    output logic measure_enable,
    output logic settle_wait,
    output logic prot_eval,
    // Temperatures and alerts
    input wire logic thermistor_pin_mode,
    input wire logic [15:0] thermistor_code,
    input wire logic [15:0] die_temp,
    input wire logic cell_overvoltage,
    input wire logic cell_undervoltage,
    // Power
    input wire logic [1:0] power_mode,
    output logic sleep_inhibit,
    output logic wake_request,
    // Balancing
    output logic [4:0] balance_switch,
    output logic balance_running_flag
);
    typedef enum logic [1:0] {ST_IDLE, ST_PENDING, ST_ACTIVE} bal_state_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Scan index mask: measure when index bits under mask are zero
    function automatic logic [3:0] rate_mask(input logic [1:0] code);
        rate_mask = 4'(({1'b0, 4'h1} << ({1'b0, code} + 3'h1)) - 5'h01);
    endfunction

    function automatic logic [31:0] settle_cycles(input logic [2:0] code);
        logic [6:0] ms;
        ms = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
        settle_cycles = 32'(ms) * 32'(MS_CYCLES);
    endfunction

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    logic [7:0] config_reg;
    logic [15:0] min_temp_reg;
    logic [15:0] max_temp_reg;
    logic [15:0] die_limit_reg;
    logic [4:0] cell_select_reg;
    bal_state_t state_reg;
    logic [3:0] scan_idx_reg;
    logic [2:0] slot_reg;
    logic [31:0] settle_reg;
    logic [31:0] prdata_next;
    logic access;
    logic mapped;
    logic cmd_write;

    assign access = psel && penable && pready;
    assign mapped = (paddr == cell_balance_pkg::OFS_CELL_SELECT) ||
                    (paddr == cell_balance_pkg::OFS_CONFIG) ||
                    (paddr == cell_balance_pkg::OFS_TEMP_LIMITS) ||
                    (paddr == cell_balance_pkg::OFS_DIE_LIMIT) ||
                    (paddr == cell_balance_pkg::OFS_STATUS);
    assign cmd_write = access && pwrite &&
                       (paddr == cell_balance_pkg::OFS_CELL_SELECT) &&
                       !config_reg[cell_balance_pkg::CFG_LOCK_BIT];

    always_comb begin
        prdata_next = 32'h0000_0000;
        unique case (paddr)
            cell_balance_pkg::OFS_CELL_SELECT:
                prdata_next = 32'(cell_select_reg);
            cell_balance_pkg::OFS_CONFIG:
                prdata_next = 32'(config_reg);
            cell_balance_pkg::OFS_TEMP_LIMITS:
                prdata_next = {max_temp_reg, min_temp_reg};
            cell_balance_pkg::OFS_DIE_LIMIT:
                prdata_next = 32'(die_limit_reg);
            cell_balance_pkg::OFS_STATUS: begin
                prdata_next[cell_balance_pkg::ST_RUN_BIT] =
                    balance_running_flag;
                prdata_next[cell_balance_pkg::ST_SW_LSB +: 5] =
                    balance_switch;
                prdata_next[cell_balance_pkg::ST_PEND_BIT] =
                    (state_reg == ST_PENDING);
                prdata_next[cell_balance_pkg::ST_SETTLE_BIT] = settle_wait;
                prdata_next[cell_balance_pkg::ST_MEAS_BIT] = measure_scan;
            end
            default: prdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= prdata_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= cell_balance_pkg::CONFIG_RST;
            min_temp_reg <= cell_balance_pkg::MIN_TEMP_RST;
            max_temp_reg <= cell_balance_pkg::MAX_TEMP_RST;
            die_limit_reg <= cell_balance_pkg::DIE_LIMIT_RST;
        end else if (access && pwrite) begin
            if (paddr == cell_balance_pkg::OFS_CONFIG) begin
                config_reg <= pwdata[7:0];
            end
            if (paddr == cell_balance_pkg::OFS_TEMP_LIMITS) begin
                min_temp_reg <= pwdata[15:0];
                max_temp_reg <= pwdata[cell_balance_pkg::TL_MAX_LSB +: 16];
            end
            if (paddr == cell_balance_pkg::OFS_DIE_LIMIT) begin
                die_limit_reg <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Stop conditions
    // ------------------------------------------------------------
    logic [1:0] decim;
    logic [1:0] loop_rate;
    logic [2:0] settle_code;
    logic temp_stop;
    logic deep;
    logic timeout_hit;
    logic stop;
    logic start_cmd;
    logic [31:0] ms_pre_reg;
    logic [15:0] ms_count_reg;

    assign decim = config_reg[cell_balance_pkg::CFG_DECIM_LSB +: 2];
    assign loop_rate = config_reg[cell_balance_pkg::CFG_LOOP_LSB +: 2];
    assign settle_code = config_reg[cell_balance_pkg::CFG_SETTLE_LSB +: 3];
    // Higher thermistor code means colder
    assign temp_stop = (thermistor_pin_mode &&
                        ((thermistor_code > min_temp_reg) ||
                         (thermistor_code < max_temp_reg))) ||
                       (die_temp > die_limit_reg);
    assign deep = (power_mode == cell_balance_pkg::PM_DEEP);
    assign timeout_hit = (ms_count_reg >= 16'(TIMEOUT_MS));
    assign start_cmd = cmd_write && (pwdata[4:0] != 5'h00) && !deep;
    // Alerts end balancing at once, no waiting for scan end
    assign stop = temp_stop || deep || timeout_hit ||
                  cell_overvoltage || cell_undervoltage;

    // ------------------------------------------------------------
    // Safety timeout, counted in whole milliseconds
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_pre_reg <= 32'h0000_0000;
            ms_count_reg <= 16'h0000;
        end else if (start_cmd || state_reg == ST_IDLE) begin
            ms_pre_reg <= 32'h0000_0000;
            ms_count_reg <= 16'h0000;
        end else if (ms_pre_reg == 32'(MS_CYCLES - 1)) begin
            ms_pre_reg <= 32'h0000_0000;
            if (!timeout_hit) begin
                ms_count_reg <= ms_count_reg + 16'h0001;
            end
        end else begin
            ms_pre_reg <= ms_pre_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Scan position
    // ------------------------------------------------------------
    logic scan_end;
    logic [3:0] cur_mask;
    logic meas_now;
    logic meas_next;

    assign scan_end = slot_tick && (slot_reg == cell_balance_pkg::SLOT_LAST);
    assign cur_mask = (state_reg == ST_ACTIVE) ?
                      rate_mask(decim) : rate_mask(loop_rate);
    assign meas_now = ((scan_idx_reg & cur_mask) == 4'h0);
    assign meas_next = (((scan_idx_reg + 4'h1) & cur_mask) == 4'h0);

    // Skipped scans still run all slots, only measurement is gated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_reg <= 3'h0;
            scan_idx_reg <= 4'h0;
        end else if (slot_tick) begin
            slot_reg <= slot_reg + 3'h1;
            if (scan_end) begin
                scan_idx_reg <= scan_idx_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measure_scan <= 1'b1;
            prot_eval <= 1'b0;
        end else begin
            measure_scan <= meas_now;
            prot_eval <= scan_end && meas_now;
        end
    end

    // ------------------------------------------------------------
    // Balancing state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cell_select_reg <= 5'h00;
        end else if (cmd_write && pwdata[4:0] == 5'h00) begin
            state_reg <= ST_IDLE;
            cell_select_reg <= 5'h00;
        end else if (start_cmd) begin
            cell_select_reg <= pwdata[4:0];
            if (state_reg == ST_IDLE) begin
                state_reg <= ST_PENDING;
            end
        end else if (stop) begin
            state_reg <= ST_IDLE;
            cell_select_reg <= 5'h00;
        end else if (state_reg == ST_PENDING && scan_end) begin
            state_reg <= ST_ACTIVE;
        end
    end

    // ------------------------------------------------------------
    // Switch drive, running flag, power
    // ------------------------------------------------------------
    logic sw_on;

    // Off for the whole measuring scan and its preceding slot
    assign sw_on = (state_reg == ST_ACTIVE) && !stop && !shared_slot &&
                   !meas_now &&
                   !(slot_reg == cell_balance_pkg::SLOT_LAST &&
                     meas_next);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            balance_switch <= 5'h00;
            balance_running_flag <= 1'b0;
            sleep_inhibit <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            balance_switch <= sw_on ? cell_select_reg : 5'h00;
            // Ignores the short measurement gaps on purpose
            balance_running_flag <= (state_reg == ST_ACTIVE) && !stop;
            sleep_inhibit <= (state_reg != ST_IDLE) || start_cmd;
            wake_request <= start_cmd &&
                            (power_mode == cell_balance_pkg::PM_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // Settling after every switch-off
    // ------------------------------------------------------------
    logic sw_falling;

    assign sw_falling = (balance_switch != 5'h00) && !sw_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_reg <= 32'h0000_0000;
        end else if (sw_falling) begin
            settle_reg <= settle_cycles(settle_code);
        end else if (settle_reg != 32'h0000_0000) begin
            settle_reg <= settle_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_wait <= 1'b0;
            measure_enable <= 1'b0;
        end else begin
            settle_wait <= sw_falling &&
                           (settle_code != 3'h0) ||
                           (settle_reg > 32'h0000_0001);
            // Voltages only with switches open and settled
            measure_enable <= meas_now && !sw_on && !sw_falling &&
                              (settle_reg <= 32'h0000_0001);
        end
    end
endmodule

/* tb/scan_sequencer.sv */
// Scan sequencer model: eight slots of two cycles per scan.
// Freezes while the scheduler reports a settle delay running.
`timescale 1ns/1ps
module scan_sequencer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Scheduler side
    input wire logic settle_wait,
    output logic slot_tick,
    output logic shared_slot
);
    logic half_reg;
    logic [2:0] slot_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_reg <= 1'b0;
            slot_reg <= 3'h0;
        end else if (!settle_wait) begin
            half_reg <= !half_reg;
            slot_reg <= slot_reg + {2'h0, half_reg};
        end
    end
    assign slot_tick = half_reg && !settle_wait;
    assign shared_slot = slot_reg == 3'h6;
endmodule

/* tb/cell_balance_monitor.sv */
// Port checker for the balancing scheduler, bound below.
// Sees only the scheduler's ports and its two timing parameters.
`timescale 1ns/1ps
module cell_balance_monitor #(
    parameter int MS_CYCLES = 10,
    parameter int TIMEOUT_MS = 20
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    // Scan, alerts, power, switches
    input wire logic shared_slot,
    input wire logic measure_enable,
    input wire logic settle_wait,
    input wire logic cell_overvoltage,
    input wire logic cell_undervoltage,
    input wire logic [1:0] power_mode,
    input wire logic sleep_inhibit,
    input wire logic [4:0] balance_switch,
    input wire logic balance_running_flag
);
    // Slack covers whole-ms rounding and the flag's lag
    localparam int LIMIT = MS_CYCLES * (TIMEOUT_MS + 1) + 3;
    int since_cmd_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_cmd_reg <= 0;
        end else if (psel && penable && pready && pwrite &&
                     paddr == cell_balance_pkg::OFS_CELL_SELECT) begin
            since_cmd_reg <= 0;
        end else if (since_cmd_reg <= LIMIT) begin
            since_cmd_reg <= since_cmd_reg + 1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_measure_off: assert property (
        measure_enable |-> balance_switch == 5'h00 && !settle_wait)
        else $error("measuring with switches on or settling");
    chk_shared_off: assert property (
        shared_slot ##1 shared_slot |-> balance_switch == 5'h00)
        else $error("switches on in shared slot");
    chk_deep_stop: assert property (
        (power_mode == cell_balance_pkg::PM_DEEP) [*3]
        |-> !balance_running_flag && balance_switch == 5'h00)
        else $error("balancing in deep low power");
    chk_alert_stop: assert property (
        (cell_overvoltage || cell_undervoltage) [*3]
        |-> !balance_running_flag && balance_switch == 5'h00)
        else $error("balancing during voltage alert");
    chk_flag_awake: assert property (
        $rose(balance_running_flag) |-> sleep_inhibit)
        else $error("running without sleep inhibit");
    chk_flag_fall: assert property (
        $fell(balance_running_flag) |-> balance_switch == 5'h00)
        else $error("flag dropped with switches on");
    chk_run_timeout: assert property (
        balance_running_flag |-> since_cmd_reg <= LIMIT)
        else $error("balancing past the timeout");
    cov_start: cover property ($rose(balance_running_flag));
    cov_settle: cover property ($rose(settle_wait));
    cov_deep: cover property ($fell(balance_running_flag) &&
        power_mode == cell_balance_pkg::PM_DEEP);
endmodule
bind cell_balance_scheduler cell_balance_monitor #(
    .MS_CYCLES(MS_CYCLES), .TIMEOUT_MS(TIMEOUT_MS)
) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .shared_slot(shared_slot), .measure_enable(measure_enable),
    .settle_wait(settle_wait), .cell_overvoltage(cell_overvoltage),
    .cell_undervoltage(cell_undervoltage), .power_mode(power_mode),
    .sleep_inhibit(sleep_inhibit), .balance_switch(balance_switch),
    .balance_running_flag(balance_running_flag)
);

/* tb/cell_balance_scheduler_test.sv */
// Self-checking bench for the balancing scheduler.
// Drives APB as master and a scan sequencer model on the scan side.
`timescale 1ns/1ps
module cell_balance_scheduler_test;
    localparam int MS_C = 10;
    localparam int TMO = 200;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed, cfg, m;
    logic slot_tick, shared_slot, measure_scan, measure_enable;
    logic settle_wait, prot_eval, thermistor_pin_mode, woke;
    logic [15:0] thermistor_code, die_temp;
    logic cell_overvoltage, cell_undervoltage, sleep_inhibit;
    logic [1:0] power_mode;
    logic wake_request, balance_running_flag;
    logic [4:0] balance_switch, mask;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int fails, n_checks, cycles, r, n, np;
    cell_balance_scheduler #(.MS_CYCLES(MS_C), .TIMEOUT_MS(TMO)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slot_tick(slot_tick),
        .shared_slot(shared_slot), .measure_scan(measure_scan),
        .measure_enable(measure_enable), .settle_wait(settle_wait),
        .prot_eval(prot_eval), .thermistor_pin_mode(thermistor_pin_mode),
        .thermistor_code(thermistor_code), .die_temp(die_temp),
        .cell_overvoltage(cell_overvoltage),
        .cell_undervoltage(cell_undervoltage), .power_mode(power_mode),
        .sleep_inhibit(sleep_inhibit), .wake_request(wake_request),
        .balance_switch(balance_switch),
        .balance_running_flag(balance_running_flag));
    scan_sequencer seq (.pclk(pclk), .presetn(presetn),
        .settle_wait(settle_wait), .slot_tick(slot_tick),
        .shared_slot(shared_slot));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] ex);
        n_checks++;
        if (seen !== ex) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (wake_request === 1'b1) woke <= 1'b1;
        if (cycles > 30000) begin
            fails++;
            close_out();
        end
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (e[33]) check("prdata", prdata, e[31:0]);
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Each note: [33] data checked, [32] error expected, then data
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       logic [33:0] ex);
        exp_q.push_back(ex);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] d, logic err);
        apb(1'b0, a, 32'h0, {1'b1, err, d});
    endtask
    task automatic wait_flag(logic v);
        n = 0;
        while (balance_running_flag !== v && n < 3000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Counts measuring scans by rise, evaluation pulses into np
    task automatic scans(int s, output int rises);
        logic prev;
        prev = measure_scan;
        rises = 0;
        np = 0;
        repeat (s * 8) begin
            @(posedge pclk);
            if (prot_eval === 1'b1) np++;
            while (slot_tick !== 1'b1) @(posedge pclk);
            if (measure_scan === 1'b1 && prev !== 1'b1) rises++;
            prev = measure_scan;
        end
    endtask
    task automatic start(logic [4:0] mk);
        wr(cell_balance_pkg::OFS_CELL_SELECT, {27'h0, mk});
        wait_flag(1'b1);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, woke} = '0;
        {cell_overvoltage, cell_undervoltage, fails, n_checks} = '0;
        {power_mode, cycles} = '0;
        thermistor_pin_mode = 1'b1;
        thermistor_code = 16'h4000;
        die_temp = 16'h0100;
        seed = 32'h0ACDDA9C;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(cell_balance_pkg::OFS_TEMP_LIMITS, 32'h0000FFFF, 1'b0);
        rd(cell_balance_pkg::OFS_DIE_LIMIT, 32'h0000FFFF, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        for (int c = 0; c < 4; c++) begin
            cfg = 32'(c * 64 + (3 - c) * 2);
            wr(cell_balance_pkg::OFS_CONFIG, cfg);
            wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h0);
            scans(16, r);
            scans(32, r);
            check("idle rate", r, 32 >> (c + 1));
            check("idle eval", np, 32 >> (c + 1));
            m = xs();
            mask = (m[4:0] == 5'h0) ? 5'h1F : m[4:0];
            wr(cell_balance_pkg::OFS_CELL_SELECT, {27'h0, mask});
            rd(cell_balance_pkg::OFS_CELL_SELECT, {27'h0, mask}, 1'b0);
            wait_flag(1'b1);
            check("flag", {31'h0, balance_running_flag}, 1);
            scans(16, r);
            scans(32, r);
            check("balance rate", r, 32 >> (4 - c));
            check("balance eval", np, 32 >> (4 - c));
            while (balance_switch === 5'h0) @(posedge pclk);
            check("switches", {27'h0, balance_switch}, {27'h0, mask});
        end
        wr(cell_balance_pkg::OFS_CONFIG, 32'h10);
        start(5'h03);
        while (settle_wait !== 1'b1) @(posedge pclk);
        n = 0;
        while (settle_wait === 1'b1) begin
            @(posedge pclk);
            n++;
        end
        check("settle", n >= 2 * MS_C && n <= 2 * MS_C + 1, 1);
        wr(cell_balance_pkg::OFS_CONFIG, 32'h0);
        wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h05);
        wait_flag(1'b1);
        r = n;
        wait_flag(1'b0);
        r = r + n;
        check("timeout", r > (TMO - 1) * MS_C && r < (TMO + 1) * MS_C, 1);
        wr(cell_balance_pkg::OFS_TEMP_LIMITS, 32'h10008000);
        wr(cell_balance_pkg::OFS_DIE_LIMIT, 32'h00000800);
        for (int k = 0; k < 7; k++) begin
            start(5'h1F);
            case (k)
                0: wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h0);
                1: thermistor_code <= 16'h9000;
                2: thermistor_code <= 16'h0800;
                3: die_temp <= 16'h0900;
                4: cell_overvoltage <= 1'b1;
                5: cell_undervoltage <= 1'b1;
                default: power_mode <= cell_balance_pkg::PM_DEEP;
            endcase
            repeat (4) @(posedge pclk);
            check("stop", {balance_switch, balance_running_flag}, 0);
            {cell_overvoltage, cell_undervoltage} <= 2'b00;
            thermistor_code <= 16'h4000;
            die_temp <= 16'h0100;
            if (k < 6) power_mode <= cell_balance_pkg::PM_NORMAL;
            @(posedge pclk);
        end
        wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h1F);
        repeat (60) @(posedge pclk);
        check("deep start", {31'h0, balance_running_flag}, 0);
        power_mode <= cell_balance_pkg::PM_SLEEP;
        start(5'h11);
        check("wake", {woke, sleep_inhibit}, 32'h3);
        power_mode <= cell_balance_pkg::PM_NORMAL;
        wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h0);
        wr(cell_balance_pkg::OFS_CONFIG, 32'h1);
        wr(cell_balance_pkg::OFS_CELL_SELECT, 32'h1F);
        rd(cell_balance_pkg::OFS_CELL_SELECT, 32'h0, 1'b0);
        repeat (60) @(posedge pclk);
        check("locked", {31'h0, balance_running_flag}, 0);
        close_out();
    end
endmodule
